// [dv/sfc_flash_if_test.sv]
// self-checking bench for the serial flash command interface
// assumes the host model on the link and a pull-up on the data line
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_if_test;
  localparam int MAW = 12;
  localparam int SAW = 10;
  logic        clk_i;
  logic        rst_n_i;
  logic        sel_n;
  logic        sclk;
  logic        sdin;
  logic        sdout;
  logic        soe;
  logic        busy;
  wire         data_line;
  int          failures;
  int          checks_done;
  logic [15:0] expq[$];
  logic [31:0] lfsr_r;
  logic [7:0]  b0;
  logic [7:0]  b1;

  // pull-up when the device is not driving
  assign data_line = soe ? sdout : 1'b1;

  // status write long enough that a whole frame fits inside the busy window
  sfc_flash_if #(.MEM_AW(MAW), .SECT_AW(SAW), .WS_CYC(400)) dut (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n_i),
    .select_low_pin_i   (sel_n),
    .serial_clock_pin_i (sclk),
    .serial_input_pin_i (sdin),
    .serial_data_pin_o  (sdout),
    .serial_data_oe_o   (soe),
    .busy_o             (busy)
  );

  sfc_host_model host (
    .select_low_pin_o   (sel_n),
    .serial_clock_pin_o (sclk),
    .serial_input_pin_o (sdin),
    .data_line_i        (data_line)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic rd(input int nbits, input logic [63:0] tx, input logic [15:0] exp);
    expq.push_back(exp);
    host.xfer(nbits, tx, 1'b1);
  endtask : rd

  task automatic cmd(input int nbits, input logic [63:0] tx);
    host.xfer(nbits, tx, 1'b0);
  endtask : cmd

  // status is read twice in one frame: the byte must repeat
  task automatic status(input logic [7:0] st);
    rd(24, 64'({sfc_pkg::OPC_RD_STAT, 16'h0000}), {st, st});
  endtask : status

  // enable ahead of each write or erase
  task automatic wren;
    cmd(8, 64'(sfc_pkg::OPC_WR_EN));
  endtask : wren

  task automatic mread(input logic [23:0] a, input logic [15:0] exp);
    rd(40, 64'({sfc_pkg::OPC_RD_BYTES, a, 8'h00}), exp);
  endtask : mread

  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge clk_i);
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 5000) begin
      failures++;
      $display("mismatch at %0t: busy never cleared", $time);
    end
  endtask : wait_idle

  initial begin : monitor
    forever begin
      @(host.got);
      check(host.rx_r, expq.pop_front());
    end
  end

  initial begin : watchdog
    #100us;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end

  initial begin : main
    rst_n_i     = 1'b0;
    failures    = 0;
    checks_done = 0;
    lfsr_r      = 32'hbcc20da1;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    status(8'h00);
    wren();
    status(8'h02);
    cmd(8, 64'(sfc_pkg::OPC_WR_DIS));
    status(8'h00);
    // enables ending off a byte boundary
    cmd(9, 64'({sfc_pkg::OPC_WR_EN, 1'b0}));
    cmd(7, 64'(sfc_pkg::OPC_WR_EN[7:1]));
    status(8'h00);
    $display("test latch done");
    b0     = lfsr_r[7:0];
    lfsr_r = lfsr_next(lfsr_r);
    b1     = lfsr_r[7:0];
    wren();
    cmd(48, 64'({sfc_pkg::OPC_WR_BYTES, 24'h0003ff, b0, b1}));
    wait_idle();
    wren();
    cmd(40, 64'({sfc_pkg::OPC_WR_BYTES, 24'h000400, b1}));
    wait_idle();
    status(8'h00);
    mread(24'h0003ff, {8'hff, b0});
    mread(24'h000300, {8'hff, b1});
    mread(24'h000400, {8'hff, b1});
    $display("test program done");
    wren();
    cmd(32, 64'({sfc_pkg::OPC_ER_SECT, 24'h000400}));
    status(8'h03);
    mread(24'h0003ff, 16'hffff);
    check({15'h0000, busy}, 16'h0001);
    wait_idle();
    mread(24'h000400, 16'hffff);
    mread(24'h0003ff, {8'hff, b0});
    status(8'h00);
    $display("test sector erase done");
    wren();
    cmd(16, 64'({sfc_pkg::OPC_WR_STAT, 8'h1c}));
    // frame ending while busy must be ignored
    cmd(8, 64'(sfc_pkg::OPC_WR_DIS));
    status(8'h03);
    wait_idle();
    status(8'h1c);
    wren();
    cmd(8, 64'(sfc_pkg::OPC_ER_BULK));
    repeat (8) @(negedge clk_i);
    check({15'h0000, busy}, 16'h0000);
    status(8'h1e);
    $display("test protect done");
    rd(48, 64'({sfc_pkg::OPC_RD_SID, 40'h0}), 16'h5a5a);
    rd(40, 64'({sfc_pkg::OPC_RD_DID, 32'h0}), 16'hffff);
    $display("test identifier done");
    close_out();
  end
endmodule : sfc_flash_if_test
`default_nettype wire

// [dv/sfc_host_model.sv]
// host model: frames each command with select and runs the serial clock
// assumes the caller never starts a frame while another one runs
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  output logic      select_low_pin_o,
  output logic      serial_clock_pin_o,
  output logic      serial_input_pin_o,
  input  wire logic data_line_i
);
  logic [15:0] rx_r;
  event        got;

  // serial clock stands low outside frames
  initial begin
    select_low_pin_o   = 1'b1;
    serial_clock_pin_o = 1'b0;
    serial_input_pin_o = 1'b1;
    rx_r               = 16'hffff;
  end

  // one fixed serial period for every command
  // msb first, select raised after last bit
  task automatic xfer(input int nbits, input logic [63:0] tx, input bit rd);
    int i;
    select_low_pin_o = 1'b0;
    #5.3;
    for (i = nbits - 1; i >= 0; i--) begin
      serial_input_pin_o = tx[i];
      #3;
      serial_clock_pin_o = 1'b1;
      rx_r               = {rx_r[14:0], data_line_i};
      #6;
      serial_clock_pin_o = 1'b0;
      #3;
    end
    select_low_pin_o = 1'b1;
    // released input flips so a stale bit never looks valid
    serial_input_pin_o = ~serial_input_pin_o;
    if (rd) begin
      ->got;
    end
    #40;
  endtask : xfer
endmodule : sfc_host_model
`default_nettype wire

// [logic/sfc_dpram.sv]
// two-clock memory: write port on one clock, registered read port on another
// assumes a location is not read while it is being written
`timescale 1ns/1ps
`default_nettype none
module sfc_dpram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          wclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] wa_i,
  input  wire logic [DW-1:0] wd_i,
  input  wire logic          rclk_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] ra_i,
  output logic      [DW-1:0] rq_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge wclk_i) begin
    if (we_i) begin
      mem[wa_i] <= wd_i;
    end
  end

  always_ff @(posedge rclk_i) begin
    if (re_i) begin
      rq_o <= mem[ra_i];
    end
  end

endmodule : sfc_dpram
`default_nettype wire

// [logic/sfc_flash_if.sv]
// serial command front end and program/erase sequencer of a configuration flash
// assumes the host stops the serial clock before raising select between frames
//
// Behaviour
// - every opcode, address and data byte moves most significant bit first
// - first input bit caught on first rising serial edge after select falls
// - read-type commands shift response out; host may stop after any bit
// - write/erase/enable/disable execute only when select rises on byte boundary
// - access other than status read or id read refused during write or erase; running cycle continues unaffected
// - write enable, no extra bytes, sets the latch in status bit 1
// - decode status read, memory read with address, silicon id with dummies
// - status write takes no address and exactly one data byte
// - write disable carries no extra bytes
// - memory write: address, one or more data bytes, last 256 kept
// - bulk erase without address, sector erase with three address bytes
// - device id read only on largest variant; silicon id on others only
// - read value output at least once, repeated or continued until select rises
// - 64 KB sectors: sector n starts at n times 0x10000
// - smallest variant uses four 32 KB sectors
// - status bit 0 is one while a write or erase cycle runs
// - latch cleared by write disable, power-up and cycle completion
// - bulk erase only when all block protect bits are zero
`timescale 1ns/1ps
`default_nettype none
module sfc_flash_if #(
  parameter int         MEM_AW  = 19,
  parameter int         SECT_AW = 16,
  parameter bit         LARGEST = 1'b0,
  parameter logic [7:0] SID_VAL = 8'h5a,  // arbitrary value
  parameter logic [7:0] DID_VAL = 8'h3c,  // arbitrary value
  parameter int         WS_CYC  = 16
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic select_low_pin_i,
  input  wire logic serial_clock_pin_i,
  input  wire logic serial_input_pin_i,
  output logic      serial_data_pin_o,
  output logic      serial_data_oe_o,
  output logic      busy_o
);

  sfc_pkg::sfc_link_s  lk_r;
  sfc_pkg::sfc_link_s  lk_nxt;
  sfc_pkg::sfc_frame_s fr_r;
  sfc_pkg::sfc_frame_s fr_nxt;
  sfc_pkg::sfc_core_s  st_r;
  sfc_pkg::sfc_core_s  st_nxt;

  logic [sfc_pkg::ST_W-1:0] stat_core;
  logic [sfc_pkg::ST_W-1:0] stat_s1;
  logic [sfc_pkg::ST_W-1:0] stat_s2;
  logic [sfc_pkg::ST_W-1:0] stat_snap;
  logic                     ack_s1;
  logic                     ack_s2;
  logic [7:0]               rx_byte;
  logic                     byte_done;
  logic [2:0]               nbyte_inc;
  logic                     has_addr;
  logic                     pb_we;
  logic [7:0]               pb_wa;
  logic                     mrd_en;
  logic [23:0]              mrd_addr;
  logic [7:0]               mem_q;
  logic                     tx_on;
  logic [7:0]               tx_src;
  logic                     out_r;
  logic                     oe_r;
  logic                     mem_we;
  logic [23:0]              mem_wa;
  logic [7:0]               mem_wd;
  logic [7:0]               pb_ra;
  logic [7:0]               pb_q;
  logic                     exec;
  logic [24:0]              sect_sz;
  logic [24:0]              mem_sz;
  logic [23:0]              smask;

  assign sect_sz = 25'(1) << SECT_AW;
  assign mem_sz  = 25'(1) << MEM_AW;
  assign smask   = sect_sz[23:0] - 24'h1;

  // link side: runs only on serial clock edges inside a frame
  assign rx_byte   = {lk_r.sh, serial_input_pin_i};
  assign byte_done = (lk_r.bitn == sfc_pkg::BYTE_LAST);
  assign nbyte_inc = (lk_r.nbyte == sfc_pkg::NBYTE_SAT) ? lk_r.nbyte : lk_r.nbyte + 3'h1;
  assign has_addr  = (fr_r.op == sfc_pkg::OPC_RD_BYTES) || (fr_r.op == sfc_pkg::OPC_WR_BYTES) ||
                     (fr_r.op == sfc_pkg::OPC_ER_SECT);

  always_comb begin
    lk_nxt   = lk_r;
    fr_nxt   = fr_r;
    pb_we    = 1'b0;
    pb_wa    = fr_r.addr[7:0] + lk_r.pidx;
    mrd_en   = 1'b0;
    mrd_addr = lk_r.ra;
    lk_nxt.sh   = rx_byte[6:0];
    lk_nxt.bitn = lk_r.bitn + 3'h1;
    fr_nxt.bitn = lk_r.bitn + 3'h1;
    if (byte_done) begin
      lk_nxt.nbyte = nbyte_inc;
      fr_nxt.nbyte = nbyte_inc;
      if (lk_r.nbyte == 3'h0) begin
        fr_nxt.op    = rx_byte;
        fr_nxt.seq   = ~ack_s2;
        lk_nxt.busy  = stat_s2[sfc_pkg::ST_WIP_BIT];
      end else if (lk_r.nbyte < sfc_pkg::HDR_ADDR && has_addr) begin
        fr_nxt.addr = {fr_r.addr[15:0], rx_byte};
      end
      if (lk_r.nbyte == sfc_pkg::HDR_OPC && fr_r.op == sfc_pkg::OPC_WR_STAT) begin
        fr_nxt.sdata = rx_byte;
      end
      // page buffer wraps, keeps last 256
      if (lk_r.nbyte >= sfc_pkg::HDR_ADDR && fr_r.op == sfc_pkg::OPC_WR_BYTES && !lk_r.busy) begin
        pb_we       = 1'b1;
        lk_nxt.pidx = lk_r.pidx + 8'h1;
        if (lk_r.dcnt != sfc_pkg::PAGE_BYTES) begin
          lk_nxt.dcnt = lk_r.dcnt + 9'h1;
        end
      end
      if (lk_r.nbyte >= 3'h3 && fr_r.op == sfc_pkg::OPC_RD_BYTES) begin
        mrd_en    = 1'b1;
        mrd_addr  = (lk_r.nbyte == 3'h3) ? {fr_r.addr[15:0], rx_byte} : lk_r.ra;
        lk_nxt.ra = mrd_addr + 24'h1;
      end
    end
    fr_nxt.dcnt = lk_nxt.dcnt;
  end

  // select high clears decoder and bit counter
  always_ff @(posedge serial_clock_pin_i or posedge select_low_pin_i) begin
    if (select_low_pin_i) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // frame record and status sync survive select so the core can read them
  always_ff @(posedge serial_clock_pin_i) begin
    fr_r    <= fr_nxt;
    stat_s1 <= stat_core;
    stat_s2 <= stat_s1;
    ack_s1  <= st_r.seq;
    ack_s2  <= ack_s1;
    if (byte_done) begin
      stat_snap <= stat_s2;
    end
  end

  always_comb begin
    tx_on  = 1'b0;
    tx_src = mem_q;
    case (fr_r.op)
      sfc_pkg::OPC_RD_STAT: begin
        tx_on  = (lk_r.nbyte >= sfc_pkg::HDR_OPC);
        tx_src = {{(8-sfc_pkg::ST_W){1'b0}}, stat_snap};
      end
      sfc_pkg::OPC_RD_BYTES: begin
        tx_on  = (lk_r.nbyte >= sfc_pkg::HDR_ADDR) && !lk_r.busy;
        tx_src = mem_q;
      end
      sfc_pkg::OPC_RD_SID: begin
        tx_on  = !LARGEST && (lk_r.nbyte >= sfc_pkg::HDR_SID);
        tx_src = SID_VAL;
      end
      sfc_pkg::OPC_RD_DID: begin
        tx_on  = LARGEST && (lk_r.nbyte >= sfc_pkg::HDR_DID);
        tx_src = DID_VAL;
      end
      default: begin
        tx_on  = 1'b0;
        tx_src = mem_q;
      end
    endcase
  end

  // byte repeats or continues until select rises
  always_ff @(negedge serial_clock_pin_i or posedge select_low_pin_i) begin
    if (select_low_pin_i) begin
      out_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      out_r <= tx_on & tx_src[~lk_r.bitn];
      oe_r  <= tx_on;
    end
  end

  assign serial_data_pin_o = out_r;
  assign serial_data_oe_o  = oe_r;

  // array read on the link clock; writes only happen while reads are refused
  sfc_dpram #(
    .AW (MEM_AW),
    .DW (8)
  ) u_array (
    .wclk_i (clk_i),
    .we_i   (mem_we),
    .wa_i   (mem_wa[MEM_AW-1:0]),
    .wd_i   (mem_wd),
    .rclk_i (serial_clock_pin_i),
    .re_i   (mrd_en),
    .ra_i   (mrd_addr[MEM_AW-1:0]),
    .rq_o   (mem_q)
  );

  // page buffer stable after the frame, drained by the core
  sfc_dpram #(
    .AW (8),
    .DW (8)
  ) u_page (
    .wclk_i (serial_clock_pin_i),
    .we_i   (pb_we),
    .wa_i   (pb_wa),
    .wd_i   (rx_byte),
    .rclk_i (clk_i),
    .re_i   (1'b1),
    .ra_i   (pb_ra),
    .rq_o   (pb_q)
  );

  // core side
  assign stat_core = {st_r.bp, st_r.wel, st_r.wip};
  // frame ends at select rise; record quiet by then
  assign exec      = st_r.s2 & ~st_r.d & (fr_r.seq != st_r.seq);

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = select_low_pin_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.d  = st_r.s2;
    mem_we    = 1'b0;
    mem_wa    = st_r.wa;
    mem_wd    = 8'hff;
    pb_ra     = st_r.pstart + st_r.pidx;
    if (exec) begin
      st_nxt.seq = fr_r.seq;
    end
    case (st_r.ex)
      sfc_pkg::EX_IDLE: begin
        if (exec && fr_r.bitn == 3'h0) begin
          case (fr_r.op)
            sfc_pkg::OPC_WR_EN: begin
              if (fr_r.nbyte == sfc_pkg::HDR_OPC) begin
                st_nxt.wel = 1'b1;
              end
            end
            sfc_pkg::OPC_WR_DIS: begin
              if (fr_r.nbyte == sfc_pkg::HDR_OPC) begin
                st_nxt.wel = 1'b0;
              end
            end
            sfc_pkg::OPC_WR_STAT: begin
              if (fr_r.nbyte == sfc_pkg::HDR_WSTAT && st_r.wel) begin
                st_nxt.ex    = sfc_pkg::EX_WSTAT;
                st_nxt.cnt   = 25'(WS_CYC);
                st_nxt.sdata = fr_r.sdata;
              end
            end
            sfc_pkg::OPC_WR_BYTES: begin
              if (fr_r.nbyte > sfc_pkg::HDR_ADDR && st_r.wel) begin
                st_nxt.ex     = sfc_pkg::EX_PROG;
                st_nxt.cnt    = {16'h0, fr_r.dcnt};
                st_nxt.base   = fr_r.addr;
                st_nxt.pstart = fr_r.addr[7:0];
                st_nxt.pidx   = 8'h0;
                st_nxt.pv     = 1'b0;
              end
            end
            // sector erase aligns to sector base
            // sector n at n times sector size
            sfc_pkg::OPC_ER_SECT: begin
              if (fr_r.nbyte == sfc_pkg::HDR_ADDR && st_r.wel) begin
                st_nxt.ex  = sfc_pkg::EX_ERASE;
                st_nxt.wa  = fr_r.addr & ~smask;
                st_nxt.cnt = sect_sz;
              end
            end
            // bulk erase blocked by protect bits
            sfc_pkg::OPC_ER_BULK: begin
              if (fr_r.nbyte == sfc_pkg::HDR_OPC && st_r.wel && st_r.bp == 3'h0) begin
                st_nxt.ex  = sfc_pkg::EX_ERASE;
                st_nxt.wa  = 24'h0;
                st_nxt.cnt = mem_sz;
              end
            end
            default: begin
              st_nxt.wel = st_r.wel;
            end
          endcase
        end
      end
      sfc_pkg::EX_PROG: begin
        if (st_r.pv) begin
          mem_we = 1'b1;
          mem_wd = pb_q;
        end
        if (st_r.cnt != 25'h0) begin
          st_nxt.pv   = 1'b1;
          st_nxt.wa   = {st_r.base[23:8], pb_ra};
          st_nxt.pidx = st_r.pidx + 8'h1;
          st_nxt.cnt  = st_r.cnt - 25'h1;
        end else begin
          st_nxt.pv = 1'b0;
          if (!st_r.pv) begin
            st_nxt.ex  = sfc_pkg::EX_IDLE;
            st_nxt.wel = 1'b0;
          end
        end
      end
      sfc_pkg::EX_ERASE: begin
        if (st_r.cnt != 25'h0) begin
          mem_we     = 1'b1;
          st_nxt.wa  = st_r.wa + 24'h1;
          st_nxt.cnt = st_r.cnt - 25'h1;
        end else begin
          st_nxt.ex  = sfc_pkg::EX_IDLE;
          st_nxt.wel = 1'b0;
        end
      end
      sfc_pkg::EX_WSTAT: begin
        if (st_r.cnt > 25'h1) begin
          st_nxt.cnt = st_r.cnt - 25'h1;
        end else begin
          st_nxt.ex  = sfc_pkg::EX_IDLE;
          st_nxt.wel = 1'b0;
          st_nxt.bp  = st_r.sdata[sfc_pkg::ST_BP_LSB +: 3];
        end
      end
      default: begin
        st_nxt.ex = sfc_pkg::EX_IDLE;
      end
    endcase
    st_nxt.wip = (st_nxt.ex != sfc_pkg::EX_IDLE);
  end

  // reset clears the enable latch; protect bits reset too
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r    <= '0;
      st_r.s1 <= 1'b1;
      st_r.s2 <= 1'b1;
      st_r.d  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.wip;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence wstat_start;
    exec && st_r.ex == sfc_pkg::EX_IDLE && fr_r.bitn == 3'h0 &&
    fr_r.op == sfc_pkg::OPC_WR_STAT && fr_r.nbyte == sfc_pkg::HDR_WSTAT && st_r.wel;
  endsequence

  sequence wstat_run;
    (st_r.ex == sfc_pkg::EX_WSTAT && st_r.wip) [*8];
  endsequence

  chk_wel_set: assert property (
    exec && st_r.ex == sfc_pkg::EX_IDLE && fr_r.bitn == 3'h0 &&
    fr_r.op == sfc_pkg::OPC_WR_EN && fr_r.nbyte == sfc_pkg::HDR_OPC |=> st_r.wel)
    else $error("enable latch not set");
  chk_wel_disable: assert property (
    exec && st_r.ex == sfc_pkg::EX_IDLE && fr_r.bitn == 3'h0 &&
    fr_r.op == sfc_pkg::OPC_WR_DIS && fr_r.nbyte == sfc_pkg::HDR_OPC |=> !st_r.wel)
    else $error("enable latch not cleared");
  chk_byte_boundary: assert property (
    exec && st_r.ex == sfc_pkg::EX_IDLE && fr_r.bitn != 3'h0
    |=> st_r.ex == sfc_pkg::EX_IDLE && $stable(st_r.wel) && $stable(st_r.bp))
    else $error("partial byte frame executed");
  chk_busy_refuse: assert property (
    exec && st_r.ex == sfc_pkg::EX_WSTAT && st_r.cnt > 25'h2
    |=> st_r.ex == sfc_pkg::EX_WSTAT && $stable(st_r.sdata) && st_r.wel)
    else $error("frame accepted while busy");
  chk_wip_state: assert property (
    busy_o == (st_r.ex != sfc_pkg::EX_IDLE) && stat_core[sfc_pkg::ST_WIP_BIT] == busy_o)
    else $error("busy bit disagrees with cycle");
  chk_done_wel: assert property (
    $fell(st_r.wip) |-> !st_r.wel ##1 !st_r.wip)
    else $error("latch left set after cycle");
  chk_bulk_protect: assert property (
    exec && st_r.ex == sfc_pkg::EX_IDLE && fr_r.op == sfc_pkg::OPC_ER_BULK &&
    st_r.bp != 3'h0 |=> st_r.ex == sfc_pkg::EX_IDLE)
    else $error("bulk erase despite protection");
  chk_page_limit: assert property (
    st_r.ex == sfc_pkg::EX_PROG |-> st_r.cnt <= {16'h0, sfc_pkg::PAGE_BYTES})
    else $error("more than one page programmed");
  chk_wstat_time: assert property (
    wstat_start |=> wstat_run)
    else $error("status write cycle cut short");
  chk_sector_base: assert property (
    st_r.ex == sfc_pkg::EX_ERASE && $past(st_r.ex) == sfc_pkg::EX_IDLE
    |-> (st_r.wa & smask) == 24'h0)
    else $error("erase not sector aligned");
  chk_status_out: assert property (
    @(posedge serial_clock_pin_i) disable iff (select_low_pin_i)
    fr_r.op == sfc_pkg::OPC_RD_STAT && lk_r.nbyte >= 3'h2 |-> oe_r)
    else $error("status not driven out");

endmodule : sfc_flash_if
`default_nettype wire

// [logic/sfc_pkg.sv]
// serial flash command interface: opcodes, status layout, frame record, states
// assumes one host frames each command with the active-low select pin
package sfc_pkg;

  localparam logic [7:0] OPC_WR_EN    = 8'h06;
  localparam logic [7:0] OPC_WR_DIS   = 8'h04;
  localparam logic [7:0] OPC_RD_STAT  = 8'h05;
  localparam logic [7:0] OPC_RD_BYTES = 8'h03;
  localparam logic [7:0] OPC_RD_SID   = 8'hab;
  localparam logic [7:0] OPC_WR_STAT  = 8'h01;
  localparam logic [7:0] OPC_WR_BYTES = 8'h02;
  localparam logic [7:0] OPC_ER_BULK  = 8'hc7;
  localparam logic [7:0] OPC_ER_SECT  = 8'hd8;
  localparam logic [7:0] OPC_RD_DID   = 8'h9f;

  // status byte: bit0 busy, bit1 write-enable latch, bits 4:2 block protect
  localparam int ST_WIP_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LSB  = 2;
  localparam int ST_W       = 5;

  // header bytes: opcode alone, opcode plus address, opcode plus dummies
  localparam logic [2:0] HDR_OPC     = 3'h1;
  localparam logic [2:0] HDR_ADDR    = 3'h4;
  localparam logic [2:0] HDR_SID     = 3'h4;
  localparam logic [2:0] HDR_DID     = 3'h3;
  localparam logic [2:0] HDR_WSTAT   = 3'h2;
  localparam logic [8:0] PAGE_BYTES  = 9'h100;
  localparam logic [2:0] BYTE_LAST   = 3'h7;
  localparam logic [2:0] NBYTE_SAT   = 3'h7;

  localparam int FMAX_READ_MHZ  = 20;
  localparam int FMAX_OTHER_MHZ = 25;

  typedef enum logic [1:0] {
    EX_IDLE  = 2'b00,
    EX_PROG  = 2'b01,
    EX_ERASE = 2'b10,
    EX_WSTAT = 2'b11
  } sfc_exec_e;

  // frame record, written on the link clock, read by the core after select rises
  typedef struct packed {
    logic        seq;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [2:0]  bitn;
    logic [2:0]  nbyte;
    logic [8:0]  dcnt;
    logic [7:0]  sdata;
  } sfc_frame_s;

  typedef struct packed {
    logic [6:0]  sh;
    logic [2:0]  bitn;
    logic [2:0]  nbyte;
    logic [8:0]  dcnt;
    logic [7:0]  pidx;
    logic [23:0] ra;
    logic        busy;
  } sfc_link_s;

  typedef struct packed {
    logic            s1;
    logic            s2;
    logic            d;
    logic            seq;
    sfc_exec_e       ex;
    logic            wip;
    logic            wel;
    logic [2:0]      bp;
    logic [24:0]     cnt;
    logic [23:0]     base;
    logic [23:0]     wa;
    logic [7:0]      pstart;
    logic [7:0]      pidx;
    logic            pv;
    logic [7:0]      sdata;
  } sfc_core_s;

endpackage : sfc_pkg
